// [design/spmc_serial_pipe_mode_control.sv]
// serial pipe mode controller: pin synchronisers, pipe state machine, byte buffer and router
// Functional notes
// - pipe pin driven low starts pipe operation in the active role, even when disabled
// - data mode follows pipe pin level only; then every byte goes to the peer
// - while enabled, weakly pull pipe pin to match pipe state; host may override
// - pin high or floating and setting disabled: pipe inactive, service hidden
// - setting enabled: idle until start command, then advertise or scan per role
// - pin floating and enabled: events flow until connection opens, then pull low
// - data state, once entered, lasts until remote disconnect or unsubscribe
// - autostart: as enabled, plus start at boot and restart after disconnect
// - pin driven high: command mode kept, no transparent data unless pin asserted
// - pin high with autostart: events stay visible while pin stays high
// - pin low at boot: start automatically whatever the setting, events suppressed
// - pull role pin to configured role; an externally driven level wins
`timescale 1ns/1ps

// ********************************************************
// byte buffer with registered output stage
// ********************************************************
module spmc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic [WIDTH-1:0] out_d;
    logic out_v;
    logic in_rdy;
  } spmc_fifo_s;

  spmc_fifo_s q_ff;
  spmc_fifo_s nxt_q;
  logic push;
  logic pop;

  always_comb
  begin
    nxt_q = q_ff;
    push = in_valid_i && q_ff.in_rdy;
    // refill the output register whenever it is empty or being drained
    pop = (q_ff.cnt != '0) && (!q_ff.out_v || out_ready_i);
    if (q_ff.out_v && out_ready_i)
    begin
      nxt_q.out_v = 1'b0;
    end
    if (pop)
    begin
      nxt_q.out_d = q_ff.mem[q_ff.rd];
      nxt_q.out_v = 1'b1;
      nxt_q.rd = AW'(q_ff.rd + 1'b1);
    end
    if (push)
    begin
      nxt_q.mem[q_ff.wr] = in_data_i;
      nxt_q.wr = AW'(q_ff.wr + 1'b1);
    end
    nxt_q.cnt = (AW+1)'(q_ff.cnt + (AW+1)'(push) - (AW+1)'(pop));
    nxt_q.in_rdy = nxt_q.cnt < (AW+1)'(DEPTH);
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q_ff <= '0;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  assign in_ready_o = q_ff.in_rdy;
  assign out_data_o = q_ff.out_d;
  assign out_valid_o = q_ff.out_v;
endmodule

// ********************************************************
// top: mode decisions, pin pulls and byte routing
// ********************************************************
module spmc_serial_pipe_mode_control (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic pipe_pin_i,
  input wire logic role_select_pin_i,
  input wire logic [1:0] enable_cfg_i,
  input wire logic role_cfg_i,
  input wire logic pipe_start_text_command_i,
  input wire logic conn_open_i,
  input wire logic remote_drop_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  output logic [7:0] peer_data_o,
  output logic peer_valid_o,
  input wire logic peer_ready_i,
  output logic [7:0] cmd_data_o,
  output logic cmd_valid_o,
  input wire logic cmd_ready_i,
  output logic pipe_pull_o,
  output logic pipe_pull_en_o,
  output logic role_select_pin_pull_o,
  output logic role_select_pin_pull_en_o,
  output logic data_mode_o,
  output logic events_enable_o,
  output logic advertise_o,
  output logic scan_o,
  output logic service_visible_o,
  output logic [1:0] mode_o
);

  typedef struct packed {
    logic [spmc_pkg::PIN_CNT-1:0] pin_s1;
    logic [spmc_pkg::PIN_CNT-1:0] pin_s2;
    logic [1:0] echo;
    logic [1:0] boot_cnt;
    logic booted;
    spmc_pkg::spmc_mode_e mode;
    logic data_mode;
    logic events;
    logic adv;
    logic scan;
    logic visible;
    logic pull_lvl;
    logic pull_en;
    logic role_lvl;
    logic [7:0] slot;
    logic peer_v;
    logic cmd_v;
  } spmc_top_s;

  spmc_top_s q_ff;
  spmc_top_s nxt_q;
  logic pin_low;
  logic ext_low;
  logic role_eff;
  logic slot_take;
  logic slot_free;
  logic [7:0] f_data;
  logic f_valid;
  logic f_in_ready;

  // state entered with no pending connection, after boot or a drop
  function automatic spmc_pkg::spmc_mode_e rest_mode(input logic low, input logic [1:0] cfg);
    if (low || cfg == spmc_pkg::EN_AUTOSTART)
    begin
      return spmc_pkg::MODE_RUN;
    end
    else if (cfg == spmc_pkg::EN_ENABLED)
    begin
      return spmc_pkg::MODE_IDLE;
    end
    return spmc_pkg::MODE_OFF;
  endfunction

  // back-pressure from the router reaches the host through rx_ready_o
  spmc_fifo #(
    .WIDTH(spmc_pkg::DATA_W),
    .DEPTH(spmc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_data_i(rx_data_i),
    .in_valid_i(rx_valid_i),
    .in_ready_o(f_in_ready),
    .out_data_o(f_data),
    .out_valid_o(f_valid),
    .out_ready_i(slot_free)
  );

  always_comb
  begin
    nxt_q = q_ff;
    // only the second stage feeds decisions
    pin_low = !q_ff.pin_s2[spmc_pkg::PIN_PIPE];
    role_eff = q_ff.pin_s2[spmc_pkg::PIN_ROLE];
    nxt_q.pin_s1 = {role_select_pin_i, pipe_pin_i};
    nxt_q.pin_s2 = q_ff.pin_s1;
    // own low pull echoes back through the pin; only a low it did not make is a request
    nxt_q.echo = {q_ff.echo[0], q_ff.pull_en && !q_ff.pull_lvl};
    ext_low = pin_low && !q_ff.echo[1];
    if (!q_ff.booted)
    begin
      nxt_q.boot_cnt = 2'(q_ff.boot_cnt + 1'b1);
      if (q_ff.boot_cnt == spmc_pkg::BOOT_WAIT)
      begin
        nxt_q.booted = 1'b1;
        nxt_q.mode = rest_mode(ext_low, enable_cfg_i);
      end
    end
    else
    begin
      case (q_ff.mode)
        spmc_pkg::MODE_OFF:
        begin
          if (ext_low)
          begin
            nxt_q.mode = spmc_pkg::MODE_RUN;
          end
          else if (enable_cfg_i != spmc_pkg::EN_DISABLED)
          begin
            nxt_q.mode = rest_mode(1'b0, enable_cfg_i);
          end
        end
        spmc_pkg::MODE_IDLE:
        begin
          if (ext_low || pipe_start_text_command_i)
          begin
            nxt_q.mode = spmc_pkg::MODE_RUN;
          end
          else
          begin
            nxt_q.mode = rest_mode(1'b0, enable_cfg_i);
          end
        end
        spmc_pkg::MODE_RUN:
        begin
          if (conn_open_i)
          begin
            nxt_q.mode = spmc_pkg::MODE_DATA;
          end
          else if (!pin_low && enable_cfg_i == spmc_pkg::EN_DISABLED)
          begin
            nxt_q.mode = spmc_pkg::MODE_OFF;
          end
        end
        spmc_pkg::MODE_DATA:
        begin
          // the configuration is not consulted until the remote side leaves
          if (remote_drop_i)
          begin
            nxt_q.mode = rest_mode(ext_low, enable_cfg_i);
          end
        end
        default:
        begin
          nxt_q.mode = spmc_pkg::MODE_OFF;
        end
      endcase
    end
    nxt_q.data_mode = pin_low;
    nxt_q.events = !pin_low;
    nxt_q.adv = nxt_q.mode == spmc_pkg::MODE_RUN && role_eff == spmc_pkg::ROLE_PERIPH;
    nxt_q.scan = nxt_q.mode == spmc_pkg::MODE_RUN && role_eff == spmc_pkg::ROLE_CENTRAL;
    nxt_q.visible = nxt_q.mode != spmc_pkg::MODE_OFF;
    // weak pull only; a driving host always wins on the wire
    nxt_q.pull_en = enable_cfg_i != spmc_pkg::EN_DISABLED || pin_low;
    nxt_q.pull_lvl = nxt_q.mode != spmc_pkg::MODE_DATA;
    nxt_q.role_lvl = role_cfg_i;
    // single output slot; destination fixed when a byte is loaded
    slot_take = (q_ff.peer_v && peer_ready_i) || (q_ff.cmd_v && cmd_ready_i);
    slot_free = !(q_ff.peer_v || q_ff.cmd_v) || slot_take;
    if (slot_take)
    begin
      nxt_q.peer_v = 1'b0;
      nxt_q.cmd_v = 1'b0;
    end
    if (slot_free && f_valid)
    begin
      nxt_q.slot = f_data;
      nxt_q.peer_v = q_ff.data_mode;
      nxt_q.cmd_v = !q_ff.data_mode;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q_ff <= '0;
      q_ff.pin_s1 <= '1;
      q_ff.pin_s2 <= '1;
      q_ff.pull_lvl <= spmc_pkg::PIPE_PULL_RESET;
      q_ff.events <= 1'b1;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  assign rx_ready_o = f_in_ready;
  assign peer_data_o = q_ff.slot;
  assign peer_valid_o = q_ff.peer_v;
  assign cmd_data_o = q_ff.slot;
  assign cmd_valid_o = q_ff.cmd_v;
  assign pipe_pull_o = q_ff.pull_lvl;
  assign pipe_pull_en_o = q_ff.pull_en;
  assign role_select_pin_pull_o = q_ff.role_lvl;
  assign role_select_pin_pull_en_o = q_ff.booted;
  assign data_mode_o = q_ff.data_mode;
  assign events_enable_o = q_ff.events;
  assign advertise_o = q_ff.adv;
  assign scan_o = q_ff.scan;
  assign service_visible_o = q_ff.visible;
  assign mode_o = q_ff.mode;

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  sequence s_pin_low_waiting;
    q_ff.booted && ext_low
      && (q_ff.mode == spmc_pkg::MODE_OFF || q_ff.mode == spmc_pkg::MODE_IDLE);
  endsequence
  sequence s_idle_waiting;
    q_ff.booted && q_ff.mode == spmc_pkg::MODE_IDLE && !pin_low
      && !pipe_start_text_command_i && enable_cfg_i == spmc_pkg::EN_ENABLED;
  endsequence
  sequence s_pin_high3;
    q_ff.booted && pipe_pin_i [*3];
  endsequence

  AST_PIN_FORCES_RUN: assert property (s_pin_low_waiting |=> q_ff.mode == spmc_pkg::MODE_RUN)
    else $error("pipe pin low did not start pipe operation");
  AST_ROUTE_BY_PIN: assert property ($rose(peer_valid_o) |-> $past(data_mode_o))
    else $error("byte sent to peer outside data mode");
  AST_PULL_LEVEL: assert property (q_ff.booted |=> pipe_pull_o == (q_ff.mode != spmc_pkg::MODE_DATA))
    else $error("pipe pull level does not match pipe state");
  AST_DISABLED_OFF: assert property (q_ff.booted && !pin_low && q_ff.mode != spmc_pkg::MODE_DATA
      && enable_cfg_i == spmc_pkg::EN_DISABLED |=> !service_visible_o)
    else $error("pipe service visible while disabled");
  AST_WAIT_START: assert property (s_idle_waiting |=> q_ff.mode == spmc_pkg::MODE_IDLE)
    else $error("left idle without start command");
  AST_START_RUNS: assert property (q_ff.booted && q_ff.mode == spmc_pkg::MODE_IDLE
      && pipe_start_text_command_i |=> advertise_o || scan_o)
    else $error("start command did not begin advertising or scanning");
  AST_CONN_PULLS_LOW: assert property (q_ff.mode == spmc_pkg::MODE_RUN && conn_open_i
      |=> q_ff.mode == spmc_pkg::MODE_DATA ##0 !pipe_pull_o)
    else $error("connection open did not pull pipe pin low");
  AST_DATA_HOLDS: assert property (q_ff.mode == spmc_pkg::MODE_DATA && !remote_drop_i
      |=> q_ff.mode == spmc_pkg::MODE_DATA)
    else $error("data state left without remote drop");
  AST_AUTO_RESTART: assert property (q_ff.mode == spmc_pkg::MODE_DATA && remote_drop_i
      && enable_cfg_i == spmc_pkg::EN_AUTOSTART |=> q_ff.mode == spmc_pkg::MODE_RUN)
    else $error("autostart did not restart after disconnect");
  AST_NO_CMD_IN_DATA: assert property ($rose(cmd_valid_o) |-> !$past(data_mode_o))
    else $error("byte sent to command path in data mode");
  AST_EVENTS_HIGH: assert property (s_pin_high3 |=> events_enable_o && !data_mode_o)
    else $error("events hidden while pipe pin high");
  AST_BOOT_LOW: assert property (!q_ff.booted && q_ff.boot_cnt == spmc_pkg::BOOT_WAIT && pin_low
      |=> q_ff.mode == spmc_pkg::MODE_RUN ##0 !events_enable_o)
    else $error("pin low at boot did not start pipe with events off");
  AST_ROLE_FROM_PIN: assert property (advertise_o |-> $past(q_ff.pin_s2[spmc_pkg::PIN_ROLE])
      == spmc_pkg::ROLE_PERIPH)
    else $error("advertising while role pin selects central");
  AST_SYNC_DELAY: assert property (q_ff.booted && $past(q_ff.booted, 3)
      |-> data_mode_o == !$past(pipe_pin_i, 3))
    else $error("data mode not three cycles behind pipe pin");
endmodule

// [design/spmc_pkg.sv]
// constants and types shared by the serial pipe mode controller
package spmc_pkg;

  // ********************************************************
  // configured enable setting
  // ********************************************************
  localparam logic [1:0] EN_DISABLED = 2'h0;
  localparam logic [1:0] EN_ENABLED = 2'h1;
  localparam logic [1:0] EN_AUTOSTART = 2'h2;

  // ********************************************************
  // role levels, shared by role_select_pin and configured role
  // ********************************************************
  localparam logic ROLE_PERIPH = 1'h0;
  localparam logic ROLE_CENTRAL = 1'h1;

  // ********************************************************
  // synchroniser bit positions and boot timing
  // ********************************************************
  localparam int PIN_PIPE = 0;
  localparam int PIN_ROLE = 1;
  localparam int PIN_CNT = 2;
  // boot_cnt value at which the synchronised pins are trusted; boot completes three cycles after reset release
  localparam logic [1:0] BOOT_WAIT = 2'h2;
  localparam logic PIPE_PULL_RESET = 1'h1;

  // ********************************************************
  // serial byte buffer
  // ********************************************************
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;

  // ********************************************************
  // pipe operation states
  // ********************************************************
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_IDLE,
    MODE_RUN,
    MODE_DATA
  } spmc_mode_e;

endpackage

// [test/spmc_host_model.sv]
// host microcontroller model: drives the pipe and role pins against the block's weak pulls
`timescale 1ns/1ps

module spmc_host_model (
  input wire logic pipe_drive_en_i,
  input wire logic pipe_drive_i,
  input wire logic pipe_pull_i,
  input wire logic pipe_pull_en_i,
  input wire logic role_drive_en_i,
  input wire logic role_drive_i,
  input wire logic role_pull_i,
  input wire logic role_pull_en_i,
  output logic pipe_pin_o,
  output logic role_pin_o
);
  // a strong host drive beats the weak pull; an undriven, unpulled pin rests on the board pull-up
  always_comb
  begin
    pipe_pin_o = 1'h1;
    role_pin_o = 1'h1;
    if (pipe_drive_en_i)
      pipe_pin_o = pipe_drive_i;
    else if (pipe_pull_en_i)
      pipe_pin_o = pipe_pull_i;
    if (role_drive_en_i)
      role_pin_o = role_drive_i;
    else if (role_pull_en_i)
      role_pin_o = role_pull_i;
  end
endmodule

// [test/spmc_serial_pipe_mode_control_tb.sv]
// self-checking bench for the serial pipe mode controller
`timescale 1ns/1ps

module spmc_serial_pipe_mode_control_tb;
  // ********************************************************
  // signals
  // ********************************************************
  logic clock_i, rst_i, role_cfg_i, pipe_start_text_command_i, conn_open_i, remote_drop_i;
  logic [1:0] enable_cfg_i;
  logic [7:0] rx_data_i;
  logic rx_valid_i, peer_ready_i, cmd_ready_i, pipe_pin_i, role_select_pin_i;
  logic pipe_drive_en_i, pipe_drive_i, role_drive_en_i, role_drive_i;
  logic rx_ready_o, peer_valid_o, cmd_valid_o, pipe_pull_o, pipe_pull_en_o;
  logic [7:0] peer_data_o, cmd_data_o;
  logic role_select_pin_pull_o, role_select_pin_pull_en_o, data_mode_o, events_enable_o;
  logic advertise_o, scan_o, service_visible_o;
  logic [1:0] mode_o;
  int bad_count, checks_done, cycles;

  spmc_serial_pipe_mode_control dut (.clock_i, .rst_i, .pipe_pin_i, .role_select_pin_i,
    .enable_cfg_i, .role_cfg_i, .pipe_start_text_command_i, .conn_open_i, .remote_drop_i,
    .rx_data_i, .rx_valid_i, .rx_ready_o, .peer_data_o, .peer_valid_o, .peer_ready_i,
    .cmd_data_o, .cmd_valid_o, .cmd_ready_i, .pipe_pull_o, .pipe_pull_en_o,
    .role_select_pin_pull_o, .role_select_pin_pull_en_o, .data_mode_o, .events_enable_o,
    .advertise_o, .scan_o, .service_visible_o, .mode_o);

  spmc_host_model host (.pipe_drive_en_i, .pipe_drive_i, .pipe_pull_i(pipe_pull_o),
    .pipe_pull_en_i(pipe_pull_en_o), .role_drive_en_i, .role_drive_i,
    .role_pull_i(role_select_pin_pull_o), .role_pull_en_i(role_select_pin_pull_en_o),
    .pipe_pin_o(pipe_pin_i), .role_pin_o(role_select_pin_i));

  // ********************************************************
  // shared tasks
  // ********************************************************
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // sample well after the edge so registered outputs have settled
  task automatic look(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic boot(input logic [1:0] en, input logic drv, input logic lvl);
    step(1);
    rst_i <= 1'h1;
    enable_cfg_i <= en;
    pipe_drive_en_i <= drv;
    pipe_drive_i <= lvl;
    step(3);
    rst_i <= 1'h0;
    look(8);
  endtask

  // which: 0 start command, 1 connection open, 2 remote drop
  task automatic pulse(input int which);
    step(1);
    if (which == 0)
      pipe_start_text_command_i <= 1'h1;
    else if (which == 1)
      conn_open_i <= 1'h1;
    else
      remote_drop_i <= 1'h1;
    step(1);
    pipe_start_text_command_i <= 1'h0;
    conn_open_i <= 1'h0;
    remote_drop_i <= 1'h0;
    look(2);
  endtask

  // ready is a register, so its level at the falling edge is what the next rising edge sees
  task automatic send(input int n, input logic [7:0] base);
    int w;
    w = 0;
    step(1);
    rx_valid_i <= 1'h1;
    rx_data_i <= base;
    for (int i = 1; i <= n; i++)
    begin
      @(negedge clock_i);
      while (rx_ready_o !== 1'h1 && w < 100)
      begin
        @(negedge clock_i);
        w++;
      end
      @(posedge clock_i);
      rx_data_i <= base + 8'(i);
      if (i == n)
        rx_valid_i <= 1'h0;
    end
  endtask

  task automatic drain(input int n, input logic [7:0] base, input logic dest);
    int w;
    step(1);
    peer_ready_i <= !dest;
    cmd_ready_i <= dest;
    for (int i = 0; i < n; i++)
    begin
      w = 0;
      @(negedge clock_i);
      while ((dest ? cmd_valid_o : peer_valid_o) !== 1'h1 && w < 100)
      begin
        @(negedge clock_i);
        w++;
      end
      chk("byte valid", 8'(dest ? cmd_valid_o : peer_valid_o), 8'h1);
      chk("byte", dest ? cmd_data_o : peer_data_o, base + 8'(i));
      @(posedge clock_i);
    end
    peer_ready_i <= 1'h0;
    cmd_ready_i <= 1'h0;
    look(3);
    chk("sinks empty", {6'h0, peer_valid_o, cmd_valid_o}, 8'h0);
  endtask

  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic t_disabled();
    role_cfg_i <= 1'h1;
    boot(spmc_pkg::EN_DISABLED, 1'h0, 1'h0);
    chk("mode", 8'(mode_o), 8'(spmc_pkg::MODE_OFF));
    chk("visible", 8'(service_visible_o), 8'h0);
    chk("events", 8'(events_enable_o), 8'h1);
    chk("pipe pull en", 8'(pipe_pull_en_o), 8'h0);
    chk("role pull", {6'h0, role_select_pin_pull_en_o, role_select_pin_pull_o}, 8'h3);
    pulse(0);
    chk("start ignored", 8'(mode_o), 8'(spmc_pkg::MODE_OFF));
    $display("test disabled done");
  endtask

  task automatic t_enabled();
    role_cfg_i <= 1'h0;
    boot(spmc_pkg::EN_ENABLED, 1'h0, 1'h0);
    chk("mode", 8'(mode_o), 8'(spmc_pkg::MODE_IDLE));
    pulse(1);
    chk("early open", {6'h0, mode_o}, 8'(spmc_pkg::MODE_IDLE));
    pulse(0);
    chk("mode", 8'(mode_o), 8'(spmc_pkg::MODE_RUN));
    chk("adv scan", {6'h0, advertise_o, scan_o}, 8'h2);
    chk("visible", 8'(service_visible_o), 8'h1);
    chk("events", 8'(events_enable_o), 8'h1);
    pulse(1);
    chk("mode", 8'(mode_o), 8'(spmc_pkg::MODE_DATA));
    chk("pull", {6'h0, pipe_pull_en_o, pipe_pull_o}, 8'h2);
    look(5);
    chk("data mode", {6'h0, data_mode_o, events_enable_o}, 8'h2);
    send(3, 8'h10);
    drain(3, 8'h10, 1'h0);
    pulse(0);
    chk("held", 8'(mode_o), 8'(spmc_pkg::MODE_DATA));
    pulse(2);
    chk("mode", 8'(mode_o), 8'(spmc_pkg::MODE_IDLE));
    chk("pull", 8'(pipe_pull_o), 8'h1);
    step(1);
    role_drive_en_i <= 1'h1;
    role_drive_i <= 1'h1;
    look(5);
    pulse(0);
    chk("role pull", 8'(role_select_pin_pull_o), 8'h0);
    chk("adv scan", {6'h0, advertise_o, scan_o}, 8'h1);
    role_drive_en_i <= 1'h0;
    $display("test enabled done");
  endtask

  task automatic t_pin_assert();
    boot(spmc_pkg::EN_DISABLED, 1'h1, 1'h1);
    step(1);
    pipe_drive_i <= 1'h0;
    look(2);
    chk("sync delay", 8'(data_mode_o), 8'h0);
    look(3);
    chk("data mode", {6'h0, data_mode_o, events_enable_o}, 8'h2);
    chk("mode", 8'(mode_o), 8'(spmc_pkg::MODE_RUN));
    send(18, 8'h40);
    look(3);
    chk("buffer full", 8'(rx_ready_o), 8'h0);
    drain(18, 8'h40, 1'h0);
    step(1);
    pipe_drive_i <= 1'h1;
    look(5);
    chk("command mode", {6'h0, data_mode_o, events_enable_o}, 8'h1);
    send(2, 8'h80);
    drain(2, 8'h80, 1'h1);
    $display("test pin assert done");
  endtask

  task automatic t_autostart();
    boot(spmc_pkg::EN_AUTOSTART, 1'h1, 1'h1);
    chk("mode", 8'(mode_o), 8'(spmc_pkg::MODE_RUN));
    pulse(1);
    look(4);
    chk("mode", 8'(mode_o), 8'(spmc_pkg::MODE_DATA));
    chk("events", {6'h0, data_mode_o, events_enable_o}, 8'h1);
    pulse(2);
    chk("restart", 8'(mode_o), 8'(spmc_pkg::MODE_RUN));
    $display("test autostart done");
  endtask

  task automatic t_boot_low();
    step(1);
    role_drive_en_i <= 1'h1;
    role_drive_i <= 1'h0;
    boot(spmc_pkg::EN_DISABLED, 1'h1, 1'h0);
    chk("mode", 8'(mode_o), 8'(spmc_pkg::MODE_RUN));
    chk("events", 8'(events_enable_o), 8'h0);
    chk("adv", 8'(advertise_o), 8'h1);
    $display("test boot low done");
  endtask

  // ********************************************************
  // main sequence
  // ********************************************************
  initial
  begin
    clock_i = 1'h0;
    forever #12.5 clock_i = ~clock_i;
  end

  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      conclude();
    end
  end

  initial
  begin
    {rst_i, role_cfg_i, pipe_start_text_command_i, conn_open_i, remote_drop_i} = 5'h10;
    {rx_valid_i, peer_ready_i, cmd_ready_i, rx_data_i, enable_cfg_i} = 13'h0;
    {pipe_drive_en_i, pipe_drive_i, role_drive_en_i, role_drive_i} = 4'h0;
    {bad_count, checks_done, cycles} = '0;
    t_disabled();
    t_enabled();
    t_pin_assert();
    t_autostart();
    t_boot_low();
    conclude();
  end
endmodule
